// file: bench/pwtf_drive_model.sv
// Power stage model: receives the switch drives and returns the fault sense lines
module pwtf_drive_model (
	input  wire logic       clk_i,       // Peripheral clock
	input  wire logic       high_i,      // High side switch drive
	input  wire logic       low_i,       // Low side switch drive
	input  wire logic [7:0] level_cmd_i, // Sense levels asked for by the bench
	output logic      [7:0] fault_o      // Fault and current-limit sense lines
);
	logic [7:0] sense; // Comparator outputs of the stage
	// Lines start quiet so the block never sees an unknown sense level
	initial sense = 8'h00;
	// Comparators settle one clock after the bench asks for a level
	always @(posedge clk_i) begin
		sense <= level_cmd_i;
	end
	assign fault_o = sense;
endmodule

// file: bench/pwtf_timebase_fault_control_tb.sv
// Self-checking bench for the PWM time base and fault control block
module pwtf_timebase_fault_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_PRE = pwtf_pkg::ADDR_PRESCALE;  // Prescale select
	localparam logic [7:0] A_PER = pwtf_pkg::ADDR_PERIOD;    // Master period
	localparam logic [7:0] A_CTL = pwtf_pkg::ADDR_GEN_CTRL;  // Generator control
	localparam logic [7:0] A_FLT = pwtf_pkg::ADDR_FAULT_LIM; // Fault and limit control
	localparam logic [7:0] A_STA = pwtf_pkg::ADDR_STATUS;    // Timer status
	logic        mclk;      // 200 MHz clock
	logic        rst_b;     // Sync reset, active low
	logic        psel;      // APB select
	logic        penable;   // APB access phase
	logic        pwrite;    // APB direction
	logic [7:0]  paddr;     // APB byte address
	logic [31:0] pwdata;    // APB write data
	logic [31:0] prdata;    // APB read data
	logic        pready;    // APB ready
	logic        pslverr;   // APB error
	logic [7:0]  fault_in;  // Sense lines from the power stage
	logic [7:0]  lvl;       // Sense levels asked of the power stage
	logic        hi;        // High side drive
	logic        lo;        // Low side drive
	logic [31:0] rng;       // Xorshift state
	logic [31:0] r;         // Random draw
	logic [31:0] q;         // Read data
	logic [31:0] t0;        // First timer sample
	logic        er;        // Error response
	logic        dn;        // Down count seen
	logic        la;        // Limit expected active
	logic        fa;        // Fault expected active
	logic [2:0]  s;         // Limit source code
	int          errors;    // Mismatches
	int          tests_run; // Comparisons
	pwtf_top pwtf_top_i (.MCLK_I(mclk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .FAULT_IN_I(fault_in),
		.HIGH_SIDE_OUTPUT_O(hi), .LOW_SIDE_OUTPUT_O(lo));
	pwtf_drive_model pwtf_drive_model_i (.clk_i(mclk), .high_i(hi), .low_i(lo),
		.level_cmd_i(lvl), .fault_o(fault_in));
	// Clock generator
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Verdict and end of run
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// Xorshift draw
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// Timer advance over one sampling gap is near 259 clocks over the divide
	function automatic logic near(input logic [15:0] dl, input int c);
		int e;
		e = (c == 7) ? 0 : (259 >> c);
		return (int'(dl) <= e + 2) && (int'(dl) + 2 >= e);
	endfunction
	// Expected {high, low} from the override setup; free running gives 1 and 0
	function automatic logic [1:0] exp_out(input logic ind, input logic l, input logic f,
		input logic [3:0] d);
		if (ind)
			return {l ? d[3] : 1'b1, f ? d[2] : 1'b0};
		if (f)
			return d[3:2];
		if (l)
			return d[1:0];
		return 2'b10;
	endfunction
	// One APB transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// No answer: give up
		if (pready !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: no ready", $time);
			final_report();
		end
	endtask
	// Wait a number of clocks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Main sequence
	initial begin
		rng = 32'd40128;
		{psel, penable, pwrite, paddr, pwdata, lvl} = '0;
		errors = 0;
		tests_run = 0;
		rst_b = 1'b0;
		tick(2);
		rst_b <= 1'b1;
		tick(1);
		check({hi, lo}, 2'b00);
		apb(0, A_PRE, 0);
		check(q, 32'h0);
		apb(0, A_PER, 0);
		check(q, 32'h0000fff8);
		apb(1, A_PRE, 32'hffffffff);
		apb(0, A_PRE, 0);
		check(q, 32'h7);
		r = 32'h10 + (xs() % 32'hffe9);
		apb(1, A_PER, {16'hffff, r[15:0]});
		apb(0, A_PER, 0);
		check(q, {16'h0, r[15:0]});
		check(er, 1'b0);
		apb(0, 8'h18, 0);
		check(er, 1'b1);
		check(q, 32'h0);
		apb(1, 8'h05, 32'h1);
		check(er, 1'b1);
		// Every divide code, the reserved one stopping the timer
		apb(1, A_PER, 32'hfff8);
		for (int c = 0; c < 8; c++) begin
			apb(1, A_CTL, 0);
			apb(1, A_PRE, c);
			apb(1, A_CTL, 32'h8000);
			apb(0, A_STA, 0);
			t0 = q;
			tick(256);
			apb(0, A_STA, 0);
			check(near(q[15:0] - t0[15:0], c), 1'b1);
		end
		// Center alignment alone, independent base alone, both
		apb(1, A_CTL, 0);
		apb(1, A_PRE, 0);
		apb(1, A_PER, 32'h10);
		for (int m = 1; m < 4; m++) begin
			apb(1, A_CTL, 0);
			apb(1, A_CTL, {16'h0, 1'b1, 5'h0, m[1], 6'h0, m[0], 2'b00});
			dn = 1'b0;
			repeat (30) begin
				apb(0, A_STA, 0);
				dn = dn | q[16];
			end
			check(dn, m == 3);
		end
		// External period reset from limit source three, limit function off
		apb(1, A_CTL, 0);
		apb(1, A_PER, 32'hfff8);
		apb(1, A_FLT, 32'h0c00);
		apb(1, A_CTL, 32'h8202);
		tick(100);
		apb(0, A_STA, 0);
		check(q[15:0] > 16'd20, 1'b1);
		lvl <= 8'h08;
		tick(4);
		apb(0, A_STA, 0);
		check(q[15:0] < 16'd6, 1'b1);
		apb(1, A_CTL, 0);
		apb(1, A_CTL, 32'h8200);
		tick(100);
		apb(0, A_STA, 0);
		check(q[15:0] > 16'd20, 1'b1);
		// Random override setups, every limit source code, reserved codes in the last third
		apb(1, A_CTL, 0);
		apb(1, A_PRE, 6);
		for (int i = 0; i < 24; i++) begin
			r = xs();
			s = i[2:0];
			apb(1, A_CTL, 0);
			// Fault source never shares the limit source's input
			apb(1, A_FLT, {16'h0, r[0], i[4], 1'b0, s, r[3], r[1],
				2'b00, s ^ 3'h4, r[4], 1'b0, r[2]});
			apb(1, pwtf_pkg::ADDR_DUTY, {16'h0, 12'hff0, r[13:10]});
			lvl <= r[21:14];
			apb(1, A_CTL, 32'h8001);
			tick(3);
			la = r[1] & ((i[4] ? 1'b0 : lvl[s]) ^ r[3]);
			fa = r[2] & (lvl[s ^ 3'h4] ^ r[4]);
			check({hi, lo}, exp_out(r[0], la, fa, r[13:10]));
		end
		// Without immediate update a new duty waits for the period boundary
		apb(1, A_CTL, 0);
		apb(1, A_FLT, 0);
		apb(1, A_PER, 32'h10);
		apb(1, pwtf_pkg::ADDR_DUTY, 0);
		apb(1, A_CTL, 32'h8001);
		apb(1, A_CTL, 32'h8000);
		apb(1, pwtf_pkg::ADDR_DUTY, 32'hfff0);
		tick(3);
		check({hi, lo}, 2'b01);
		tick(1100);
		check({hi, lo}, 2'b10);
		// The block raises no interrupt, so no status waits to be acknowledged
		final_report();
	end
endmodule

// file: rtl/pwtf_pkg.sv
// Constants, register map and field layout of the PWM time base and fault control block
package pwtf_pkg;
	// Register byte offsets on APB
	localparam logic [7:0]  ADDR_PRESCALE  = 8'h00;
	localparam logic [7:0]  ADDR_PERIOD    = 8'h04;
	localparam logic [7:0]  ADDR_GEN_CTRL  = 8'h08;
	localparam logic [7:0]  ADDR_FAULT_LIM = 8'h0c;
	localparam logic [7:0]  ADDR_DUTY      = 8'h10;
	localparam logic [7:0]  ADDR_STATUS    = 8'h14;
	// Reset values
	localparam logic [2:0]  PRESCALE_RST   = 3'h0;
	localparam logic [15:0] PERIOD_RST     = 16'hfff8;
	localparam logic [15:0] GEN_CTRL_RST   = 16'h0000;
	localparam logic [15:0] FAULT_LIM_RST  = 16'h0000;
	localparam logic [15:0] DUTY_RST       = 16'h0000;
	// Prescaler
	localparam logic [2:0]  PRESCALE_RSVD  = 3'h7;
	localparam int          PRESCALE_W     = 3;
	// Generator control fields
	localparam int GC_TB_EN   = 15;
	localparam int GC_ITB     = 9;
	localparam int GC_CAM     = 2;
	localparam int GC_EXTERNAL_PERIOD_RESET_CTL   = 1;
	localparam int GC_IUE     = 0;
	// Fault and limit control fields
	localparam int FL_IFLT    = 15;
	localparam int FL_CURRENT_LIMIT_SOURCE_SELECT_H = 14;
	localparam int FL_CURRENT_LIMIT_SOURCE_SELECT_L = 10;
	localparam int FL_CURRENT_LIMIT_POLARITY   = 9;
	localparam int FL_CLEN    = 8;
	localparam int FL_FSRC_H  = 7;
	localparam int FL_FSRC_L  = 3;
	localparam int FL_FPOL    = 2;
	localparam int FL_FEN     = 0;
	// Duty register override data fields
	localparam int DU_CURRENT_LIMIT_OVERRIDE_DATA_H = 1;
	localparam int DU_FDAT_H  = 3;
	localparam int DU_FDAT_L  = 2;
	// Source codes above this are reserved
	localparam logic [4:0]  SRC_MAX        = 5'h07;
	localparam int          NUM_FAULT      = 8;
	// Time base count direction
	typedef enum logic [0:0] {
		PWTF_UP   = 1'b0,
		PWTF_DOWN = 1'b1
	} pwtf_dir_t;
endpackage

// file: rtl/pwtf_top.sv
// PWM time base with prescaler, period, alignment and fault/current-limit override
//
// The APB slave port and the register offsets were left to the implementer.
module pwtf_top (
	input  wire logic        MCLK_I,    // Peripheral clock
	input  wire logic        RST_B_I,   // Synchronous reset, active low
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic [7:0]  FAULT_IN_I, // Fault inputs one to eight
	output logic             HIGH_SIDE_OUTPUT_O,
	output logic             LOW_SIDE_OUTPUT_O
);
	logic [2:0]  input_clock_divide_select; // Prescale code
	logic [15:0] master_period_value;       // Period register
	logic [15:0] gen_ctrl;                  // Generator control register
	logic [15:0] fault_lim;                 // Fault and limit register
	logic [15:0] duty_pend;                 // Written duty and override data
	logic [15:0] duty_act;                  // Active duty
	logic [5:0]  pre_cnt;                   // Prescale counter
	logic        tick;                      // Divided clock enable
	logic [15:0] master_timer;              // Time base counter
	pwtf_pkg::pwtf_dir_t dir;               // Count direction
	logic        period_end;                // Period boundary
	logic        cl_act;                    // Current limit active
	logic        flt_act;                   // Fault active
	logic        wr_en;                     // APB write strobe
	logic        rd_en;                     // APB read strobe
	logic        next_high;
	logic        next_low;

	// Picks fault input one plus code, zero for reserved codes
	function automatic logic src_pick(input logic [4:0] code, input logic [7:0] pins);
		logic r;
		r = 1'b0;
		if (code <= pwtf_pkg::SRC_MAX) begin
			r = pins[code[2:0]];
		end
		return r;
	endfunction

	// Divide-by terminal count for a prescale code
	function automatic logic [5:0] pre_term(input logic [2:0] code);
		logic [6:0] d;
		d = 7'h01 << code;
		return 6'(d - 7'h01);
	endfunction

	// Field decodes of the control registers
	wire time_base_enable_bit = gen_ctrl[pwtf_pkg::GC_TB_EN];
	wire independent_time_base = gen_ctrl[pwtf_pkg::GC_ITB];
	wire center_align_enable = gen_ctrl[pwtf_pkg::GC_CAM];
	wire external_period_reset_ctl = gen_ctrl[pwtf_pkg::GC_EXTERNAL_PERIOD_RESET_CTL];
	wire immediate_update_enable = gen_ctrl[pwtf_pkg::GC_IUE];
	wire independent_fault_mode = fault_lim[pwtf_pkg::FL_IFLT];
	wire current_limit_polarity = fault_lim[pwtf_pkg::FL_CURRENT_LIMIT_POLARITY];
	wire current_limit_enable = fault_lim[pwtf_pkg::FL_CLEN];
	wire [4:0] current_limit_source_select = fault_lim[pwtf_pkg::FL_CURRENT_LIMIT_SOURCE_SELECT_H:pwtf_pkg::FL_CURRENT_LIMIT_SOURCE_SELECT_L];
	wire [4:0] fault_source_select = fault_lim[pwtf_pkg::FL_FSRC_H:pwtf_pkg::FL_FSRC_L];
	wire [1:0] current_limit_override_data = duty_pend[pwtf_pkg::DU_CURRENT_LIMIT_OVERRIDE_DATA_H:0];
	wire [1:0] fault_override_data = duty_pend[pwtf_pkg::DU_FDAT_H:pwtf_pkg::DU_FDAT_L];
	// Effective alignment, limit source and external reset
	wire cam_eff = center_align_enable & independent_time_base;
	wire cl_raw = src_pick(current_limit_source_select, FAULT_IN_I);
	wire ext_reset = external_period_reset_ctl & independent_time_base
		& (cl_raw ^ current_limit_polarity);

	// Write lands in the access phase; read data is captured in setup
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_en = PSEL_I & ~PENABLE_I & ~PWRITE_I;

	// Limit and fault detection with polarity
	always_comb begin
		cl_act = current_limit_enable & (cl_raw ^ current_limit_polarity);
		flt_act = fault_lim[pwtf_pkg::FL_FEN]
			& (src_pick(fault_source_select, FAULT_IN_I) ^ fault_lim[pwtf_pkg::FL_FPOL]);
	end

	// Register writes
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			input_clock_divide_select <= pwtf_pkg::PRESCALE_RST;
			master_period_value <= pwtf_pkg::PERIOD_RST;
			gen_ctrl <= pwtf_pkg::GEN_CTRL_RST;
			fault_lim <= pwtf_pkg::FAULT_LIM_RST;
			duty_pend <= pwtf_pkg::DUTY_RST;
		end else if (wr_en) begin
			unique case (PADDR_I)
				pwtf_pkg::ADDR_PRESCALE: begin
					input_clock_divide_select <= PWDATA_I[2:0];
				end
				pwtf_pkg::ADDR_PERIOD: begin
					master_period_value <= PWDATA_I[15:0];
				end
				pwtf_pkg::ADDR_GEN_CTRL: begin
					gen_ctrl <= PWDATA_I[15:0];
				end
				pwtf_pkg::ADDR_FAULT_LIM: begin
					fault_lim <= PWDATA_I[15:0];
				end
				pwtf_pkg::ADDR_DUTY: begin
					duty_pend <= PWDATA_I[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Active duty update, immediate or at period boundary
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			duty_act <= pwtf_pkg::DUTY_RST;
		end else if (immediate_update_enable | period_end) begin
			duty_act <= duty_pend;
		end
	end

	// Prescaler fed by the peripheral clock
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I || !time_base_enable_bit) begin
			pre_cnt <= 6'h00;
			tick <= 1'b0;
		end else if (input_clock_divide_select == pwtf_pkg::PRESCALE_RSVD) begin
			pre_cnt <= 6'h00; // Reserved code stops the time base
			tick <= 1'b0;
		end else if (pre_cnt >= pre_term(input_clock_divide_select)) begin
			pre_cnt <= 6'h00;
			tick <= 1'b1;
		end else begin
			pre_cnt <= pre_cnt + 6'h01;
			tick <= 1'b0;
		end
	end

	// Period boundary: top of an edge-aligned count or bottom of a center-aligned one
	assign period_end = tick & ((dir == pwtf_pkg::PWTF_UP)
		? (master_timer >= master_period_value) & ~cam_eff
		: (master_timer == 16'h0000));

	// Master timer: edge or center aligned, external reset
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I || !time_base_enable_bit) begin
			master_timer <= 16'h0000;
			dir <= pwtf_pkg::PWTF_UP;
		end else if (ext_reset) begin
			master_timer <= 16'h0000;
			dir <= pwtf_pkg::PWTF_UP;
		end else if (tick) begin
			if (!cam_eff) begin
				dir <= pwtf_pkg::PWTF_UP;
				master_timer <= (master_timer >= master_period_value) ? 16'h0000
					: master_timer + 16'h0001;
			end else if (dir == pwtf_pkg::PWTF_UP) begin
				if (master_timer >= master_period_value) begin
					dir <= pwtf_pkg::PWTF_DOWN;
					master_timer <= master_timer - 16'h0001;
				end else begin
					master_timer <= master_timer + 16'h0001;
				end
			end else begin
				if (master_timer == 16'h0000) begin
					dir <= pwtf_pkg::PWTF_UP;
					master_timer <= 16'h0001;
				end else begin
					master_timer <= master_timer - 16'h0001;
				end
			end
		end else if (!cam_eff) begin
			dir <= pwtf_pkg::PWTF_UP; // Leaving center mode ends a down count at once
		end
	end

	// Output mapping with override priority
	always_comb begin
		next_high = time_base_enable_bit & (master_timer < duty_act);
		next_low = time_base_enable_bit & ~next_high;
		if (independent_fault_mode) begin
			if (cl_act) begin
				next_high = fault_override_data[1];
			end
			if (flt_act) begin
				next_low = fault_override_data[0];
			end
		end else if (flt_act) begin
			next_high = fault_override_data[1];
			next_low = fault_override_data[0];
		end else if (cl_act) begin
			next_high = current_limit_override_data[1];
			next_low = current_limit_override_data[0];
		end
	end

	// Registered outputs
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			HIGH_SIDE_OUTPUT_O <= 1'b0;
			LOW_SIDE_OUTPUT_O <= 1'b0;
		end else begin
			HIGH_SIDE_OUTPUT_O <= next_high;
			LOW_SIDE_OUTPUT_O <= next_low;
		end
	end

	// APB read data, no wait state
	always_ff @(posedge MCLK_I) begin
		if (!RST_B_I) begin
			PRDATA_O <= 32'h00000000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I & ~PENABLE_I;
			PSLVERR_O <= PSEL_I & ~PENABLE_I & (PADDR_I > pwtf_pkg::ADDR_STATUS | PADDR_I[1:0] != 2'h0);
			if (rd_en) begin
				unique case (PADDR_I)
					pwtf_pkg::ADDR_PRESCALE: PRDATA_O <= {29'h0, input_clock_divide_select};
					pwtf_pkg::ADDR_PERIOD: PRDATA_O <= {16'h0, master_period_value};
					pwtf_pkg::ADDR_GEN_CTRL: PRDATA_O <= {16'h0, gen_ctrl};
					pwtf_pkg::ADDR_FAULT_LIM: PRDATA_O <= {16'h0, fault_lim};
					pwtf_pkg::ADDR_DUTY: PRDATA_O <= {16'h0, duty_pend};
					pwtf_pkg::ADDR_STATUS: PRDATA_O <= {13'h0, flt_act, cl_act, dir, master_timer};
					default: PRDATA_O <= 32'h00000000;
				endcase
			end
		end
	end

	// Prescale register resets to divide-by-1
	AST_PRESCALE_RST: assert property (@(posedge MCLK_I) !RST_B_I |=> input_clock_divide_select == 3'h0)
		else $error("prescale not reset to divide-by-1");
	// Period resets to 0xfff8
	AST_PERIOD_RST: assert property (@(posedge MCLK_I) !RST_B_I |=> master_period_value == 16'hfff8)
		else $error("period reset wrong");
	// Divide-by-2 gives ticks every second cycle
	AST_DIV2: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		tick && input_clock_divide_select == 3'h1 && $stable(input_clock_divide_select) && time_base_enable_bit
		|=> !tick)
		else $error("divide-by-2 tick spacing wrong");
	// Without independent base the timer never counts down
	AST_CAM_IGNORED: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!independent_time_base |=> dir == pwtf_pkg::PWTF_UP || $past(independent_time_base))
		else $error("center mode active without independent base");
	// External reset clears timer
	AST_EXT_RESET: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		ext_reset && time_base_enable_bit |=> master_timer == 16'h0000)
		else $error("external reset did not clear timer");
	// Immediate update copies duty next cycle
	AST_IUE: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		immediate_update_enable |=> duty_act == $past(duty_pend))
		else $error("immediate duty update missing");
	// Normal-mode fault drives both outputs
	AST_FAULT_BOTH: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!independent_fault_mode && flt_act |=> {HIGH_SIDE_OUTPUT_O, LOW_SIDE_OUTPUT_O} == $past(fault_override_data))
		else $error("fault override wrong");
	// Independent mode limit drives high output only
	AST_IND_LIMIT: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		independent_fault_mode && cl_act |=> HIGH_SIDE_OUTPUT_O == $past(fault_override_data[1]))
		else $error("independent limit mapping wrong");
	// Reserved source codes read as a low input, so the limit follows enable and polarity alone
	AST_SRC_RSVD: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		current_limit_source_select > 5'h07 |-> cl_act == (current_limit_enable & current_limit_polarity))
		else $error("reserved source used");
	// Reserved prescale code holds the time base still
	AST_RSVD_STOP: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		input_clock_divide_select == pwtf_pkg::PRESCALE_RSVD |=> !tick)
		else $error("reserved prescale code produced a tick");
	// Divide-by-1 ticks on every enabled cycle after the first
	AST_DIV1: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		time_base_enable_bit && $past(time_base_enable_bit) && $stable(input_clock_divide_select)
		&& input_clock_divide_select == pwtf_pkg::PRESCALE_RST |-> tick)
		else $error("divide-by-1 missed a tick");
	// Edge-aligned count wraps to zero at the period
	AST_EDGE_WRAP: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		time_base_enable_bit && !ext_reset && tick && !cam_eff
		&& master_timer >= master_period_value |=> master_timer == 16'h0000)
		else $error("edge-aligned count did not wrap");
	// Independent mode fault drives low output only
	AST_IND_FAULT: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		independent_fault_mode && flt_act |=> LOW_SIDE_OUTPUT_O == $past(fault_override_data[0]))
		else $error("independent fault mapping wrong");
	// Normal-mode limit without fault drives both outputs from limit data
	AST_LIMIT_BOTH: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!independent_fault_mode && cl_act && !flt_act
		|=> {HIGH_SIDE_OUTPUT_O, LOW_SIDE_OUTPUT_O} == $past(current_limit_override_data))
		else $error("limit override wrong");
	// Limit function off keeps the limit inactive
	AST_LIMIT_OFF: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		!current_limit_enable |-> !cl_act)
		else $error("limit active while disabled");
	// Misaligned address answers with an error in the access phase
	AST_SLVERR: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
		PSEL_I && !PENABLE_I && PADDR_I[1:0] != 2'h0 |=> PSLVERR_O && PREADY_O)
		else $error("misaligned access not refused");
	// Main scenarios the bench reaches
	COV_CENTER: cover property (@(posedge MCLK_I) dir == pwtf_pkg::PWTF_DOWN);
	COV_IND_LIMIT: cover property (@(posedge MCLK_I) cl_act && independent_fault_mode);
	COV_FAULT: cover property (@(posedge MCLK_I) flt_act && !independent_fault_mode);
	COV_EXTRST: cover property (@(posedge MCLK_I) ext_reset && time_base_enable_bit);
endmodule
